// ==== verilog/aux_pin_config_port.sv ====
// auxiliary pin configuration port with register slave and interrupt
//
// Decided for this implementation: strobed register access.
`default_nettype none
// Operation
// RULE1: direction bit clear makes pin an input, set makes it driven output
// RULE2: polarity clear means low input is true, set means high is true
// RULE3: level mode status bit is one while pin sits at asserted level
// RULE4: edge mode status latches once asserted, cleared by status register read
// RULE5: polarity and sensing settings affect only pins configured as inputs
// RULE6: output state bit sets driven level; ignored while pin is input
// RULE7: power-on and suspend revert pins 4,5 output high, pin 6 output low
// RULE8: register 5B holds all four settings for pins 5 and 6
// RULE9: register 5A holds pin 4 settings beside pin 3, same layout
// RULE10: in 5B pin 5 uses bits 0-3, pin 6 bits 4-7
module aux_pin_config_port
  import aux_pin_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              SUSPEND,
  // register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  // pins 3 to 6, index 0 is pin 3
  input  wire logic [3:0]        PIN_I,
  output logic      [3:0]        PIN_O,
  output logic      [3:0]        PIN_OE,
  // interrupt
  output logic                   IRQ
);
  // ==========================================================
  // configuration registers
  logic [7:0] cfg34_r;
  logic [7:0] cfg34_nxt;
  logic [7:0] cfg56_r;
  logic [7:0] cfg56_nxt;
  logic [3:0] irq_en_r;
  logic [3:0] irq_en_nxt;

  always_comb begin
    cfg34_nxt  = cfg34_r;
    cfg56_nxt  = cfg56_r;
    irq_en_nxt = irq_en_r;
    if (WR && ADDR == OFF_CFG_34) begin
      cfg34_nxt = WDATA;                                 // RULE9
    end else if (WR && ADDR == OFF_CFG_56) begin
      cfg56_nxt = WDATA;                                 // RULE8
    end else if (WR && ADDR == OFF_IRQ_ENABLE) begin
      irq_en_nxt = WDATA[3:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || SUSPEND) begin
      cfg34_r  <= RST_CFG_34;                            // RULE7
      cfg56_r  <= RST_CFG_56;                            // RULE7
      irq_en_r <= 4'h0;
    end else begin
      cfg34_r  <= cfg34_nxt;
      cfg56_r  <= cfg56_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // ==========================================================
  // pin cells
  logic [15:0] cfg_all;
  logic [3:0]  pin_sync;
  logic [3:0]  state;
  logic [3:0]  event_lvl;
  logic        status_rd;

  assign cfg_all   = {cfg56_r, cfg34_r};                 // RULE10
  assign status_rd = RD && (ADDR == OFF_PIN_STATUS);     // RULE4

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      aux_pin_sync u_sync (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .D       (PIN_I[g]),
        .Q       (pin_sync[g])
      );
      aux_pin_cell u_cell (
        .CLK       (CLK),
        .SYS_RST   (SYS_RST),
        .SUSPEND   (SUSPEND),
        .CFG       (cfg_all[4*g +: 4]),
        .PIN_SYNC  (pin_sync[g]),
        .STATUS_RD (status_rd),
        .PIN_O     (PIN_O[g]),
        .PIN_OE    (PIN_OE[g]),
        .STATE     (state[g]),
        .EVENT     (event_lvl[g])
      );
    end
  endgenerate

  // ==========================================================
  // interrupt status: rising assertion sets, clear register clears
  logic [3:0] evt_prev_r;
  logic [3:0] evt_prev_nxt;
  logic [3:0] irq_st_r;
  logic [3:0] irq_st_nxt;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;

  always_comb begin
    irq_set      = event_lvl & ~evt_prev_r;
    irq_clr      = (WR && ADDR == OFF_IRQ_CLEAR) ? WDATA[3:0] : 4'h0;
    irq_st_nxt   = (irq_st_r & ~irq_clr) | irq_set;
    evt_prev_nxt = event_lvl;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || SUSPEND) begin
      irq_st_r   <= 4'h0;
      evt_prev_r <= 4'h0;
    end else begin
      irq_st_r   <= irq_st_nxt;
      evt_prev_r <= evt_prev_nxt;
    end
  end

  assign IRQ = |(irq_st_r & irq_en_r);

  // ==========================================================
  // read data, one cycle after the strobe
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 8'h00;
    if (RD) begin
      if (ADDR == OFF_CFG_34) begin
        rdata_nxt = cfg34_r;
      end else if (ADDR == OFF_CFG_56) begin
        rdata_nxt = cfg56_r;
      end else if (ADDR == OFF_PIN_STATUS) begin
        rdata_nxt = {4'h0, state};                       // RULE3 RULE4
      end else if (ADDR == OFF_IRQ_STATUS) begin
        rdata_nxt = {4'h0, irq_st_r};
      end else if (ADDR == OFF_IRQ_ENABLE) begin
        rdata_nxt = {4'h0, irq_en_r};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ==========================================================
  // checks
  property p_reset_cfg;
    @(posedge CLK) (SYS_RST || SUSPEND) |=> (cfg56_r == RST_CFG_56 && cfg34_r[7:4] == RST_NIB_OUT_HI);
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reset defaults wrong"); // RULE7

  property p_reset_pins;
    @(posedge CLK) (SYS_RST || SUSPEND) |=> (PIN_OE[3:1] == 3'b111 && PIN_O[3:1] == 3'b011);
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("reset pin drive wrong"); // RULE7

  property p_wr56;
    @(posedge CLK) disable iff (SYS_RST || SUSPEND)
      (WR && ADDR == OFF_CFG_56) |=> (cfg56_r == $past(WDATA) && PIN_OE[2] == $past(WDATA[FLD_DIR]));
  endproperty
  a_wr56: assert property (p_wr56) else $error("5B write lost"); // RULE8 RULE10

  property p_wr34;
    @(posedge CLK) disable iff (SYS_RST || SUSPEND)
      (WR && ADDR == OFF_CFG_34) |=> (PIN_OE[1] == $past(WDATA[4+FLD_DIR]));
  endproperty
  a_wr34: assert property (p_wr34) else $error("5A pin4 field wrong"); // RULE9

  property p_read_clears;
    @(posedge CLK) disable iff (SYS_RST || SUSPEND)
      (status_rd && !(|event_lvl)) ##1 !(|event_lvl) |-> (g_pin[0].u_cell.edge_r == 1'b0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("edge not cleared by read"); // RULE4

  property p_irq_sticky;
    @(posedge CLK) disable iff (SYS_RST || SUSPEND)
      (|irq_set) |=> (|irq_st_r);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt status lost");

  // ==========================================================
  // read path checks
  // no strobe, no data
  property p_rdata_idle;
    @(posedge CLK) disable iff (SYS_RST)
      !RD |=> (RDATA == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

  // pins 5 and 6 register reads back
  property p_rdata_cfg56;
    @(posedge CLK) disable iff (SYS_RST)
      (RD && ADDR == OFF_CFG_56) |=> (RDATA == $past(cfg56_r));
  endproperty
  a_rdata_cfg56: assert property (p_rdata_cfg56) else $error("5B read wrong"); // RULE8

  // pins 3 and 4 register reads back
  property p_rdata_cfg34;
    @(posedge CLK) disable iff (SYS_RST)
      (RD && ADDR == OFF_CFG_34) |=> (RDATA == $past(cfg34_r));
  endproperty
  a_rdata_cfg34: assert property (p_rdata_cfg34) else $error("5A read wrong"); // RULE9

  // status read shows pin states of the strobe cycle
  property p_rdata_status;
    @(posedge CLK) disable iff (SYS_RST)
      (RD && ADDR == OFF_PIN_STATUS) |=> (RDATA[3:0] == $past(state) && RDATA[7:4] == 4'h0);
  endproperty
  a_rdata_status: assert property (p_rdata_status) else $error("status read wrong"); // RULE3 RULE4

  // ==========================================================
  // interrupt checks
  // clear without a new event empties the bits
  property p_irq_clear;
    @(posedge CLK) disable iff (SYS_RST || SUSPEND)
      (WR && ADDR == OFF_IRQ_CLEAR && irq_set == 4'h0) |=> ((irq_st_r & $past(WDATA[3:0])) == 4'h0);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt clear lost");

  // masked status never raises the line
  property p_irq_mask;
    @(posedge CLK) disable iff (SYS_RST)
      (irq_en_r == 4'h0) |-> !IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");

  // suspend empties interrupt status
  property p_susp_irq;
    @(posedge CLK) SUSPEND |=> (irq_st_r == 4'h0 && !IRQ);
  endproperty
  a_susp_irq: assert property (p_susp_irq) else $error("suspend kept interrupt");

  // ==========================================================
  // pin drive checks
  // pins 5 and 6 direction from their nibbles
  property p_oe56;
    @(posedge CLK) disable iff (SYS_RST)
      1'b1 |-> (PIN_OE[3] == cfg56_r[4+FLD_DIR] && PIN_OE[2] == cfg56_r[FLD_DIR]);
  endproperty
  a_oe56: assert property (p_oe56) else $error("pin 5/6 direction wrong"); // RULE1 RULE10

  // pin 6 driven level
  property p_pin6_level;
    @(posedge CLK) disable iff (SYS_RST)
      PIN_OE[3] |-> (PIN_O[3] == cfg56_r[4+FLD_OUT]);
  endproperty
  a_pin6_level: assert property (p_pin6_level) else $error("pin 6 level wrong"); // RULE6 RULE10

  // pin 5 driven level
  property p_pin5_level;
    @(posedge CLK) disable iff (SYS_RST)
      PIN_OE[2] |-> (PIN_O[2] == cfg56_r[FLD_OUT]);
  endproperty
  a_pin5_level: assert property (p_pin5_level) else $error("pin 5 level wrong"); // RULE6 RULE10

  // pin 4 driven level
  property p_pin4_level;
    @(posedge CLK) disable iff (SYS_RST)
      PIN_OE[1] |-> (PIN_O[1] == cfg34_r[4+FLD_OUT]);
  endproperty
  a_pin4_level: assert property (p_pin4_level) else $error("pin 4 level wrong"); // RULE9

  // unmapped writes leave configuration alone
  property p_unmapped_wr;
    @(posedge CLK) disable iff (SYS_RST || SUSPEND)
      (WR && ADDR != OFF_CFG_34 && ADDR != OFF_CFG_56) |=> ($stable(cfg34_r) && $stable(cfg56_r));
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("stray write changed config"); // RULE8 RULE9
endmodule // aux_pin_config_port
`default_nettype wire

// ==== verilog/aux_pin_pkg.sv ====
// constants for the auxiliary pin configuration port
`default_nettype none
package aux_pin_pkg;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 8;
  // register offsets
  localparam logic [7:0]  OFF_CFG_34     = 8'h5A;
  localparam logic [7:0]  OFF_CFG_56     = 8'h5B;
  localparam logic [7:0]  OFF_PIN_STATUS = 8'h60;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h61;
  localparam logic [7:0]  OFF_IRQ_ENABLE = 8'h62;
  localparam logic [7:0]  OFF_IRQ_CLEAR  = 8'h63;
  // field positions inside a four-bit pin nibble
  localparam int unsigned FLD_DIR        = 0;
  localparam int unsigned FLD_POL        = 1;
  localparam int unsigned FLD_EDGE       = 2;
  localparam int unsigned FLD_OUT        = 3;
  // reset values: pins 4,5 output high, pin 6 output low, pin 3 input
  localparam logic [7:0]  RST_CFG_34     = 8'h90;
  localparam logic [7:0]  RST_CFG_56     = 8'h39;
  localparam logic [3:0]  RST_NIB_IN     = 4'h0;
  localparam logic [3:0]  RST_NIB_OUT_HI = 4'h9;
  localparam logic [3:0]  RST_NIB_OUT_LO = 4'h1;
endpackage
`default_nettype wire

// ==== verilog/aux_pin_sync.sv ====
// two flip-flop synchroniser for one pin input
`default_nettype none
module aux_pin_sync (
  // clock and reset
  input  wire logic CLK,
  input  wire logic SYS_RST,
  // data
  input  wire logic D,
  output logic      Q
);
  logic meta_r;
  logic q_r;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta_r <= 1'b0;
      q_r    <= 1'b0;
    end else begin
      meta_r <= D;
      q_r    <= meta_r;
    end
  end
  assign Q = q_r;
endmodule // aux_pin_sync
`default_nettype wire

// ==== verilog/aux_pin_cell.sv ====
// one auxiliary pin: direction, drive, polarity and sensing
`default_nettype none
module aux_pin_cell
  import aux_pin_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       SUSPEND,
  // configuration nibble
  input  wire logic [3:0] CFG,
  // synchronised pin level
  input  wire logic       PIN_SYNC,
  // status read clears edge latch
  input  wire logic       STATUS_RD,
  // pin drive
  output logic            PIN_O,
  output logic            PIN_OE,
  // status bit and event
  output logic            STATE,
  output logic            EVENT
);
  logic edge_r;
  logic edge_nxt;
  logic asserted;
  logic is_input;

  assign is_input = ~CFG[FLD_DIR];                              // RULE1
  assign PIN_OE   = CFG[FLD_DIR];                               // RULE1
  assign PIN_O    = CFG[FLD_DIR] & CFG[FLD_OUT];                // RULE6
  assign asserted = is_input & (PIN_SYNC == CFG[FLD_POL]);      // RULE2 RULE5

  always_comb begin
    edge_nxt = edge_r;
    if (STATUS_RD) begin
      edge_nxt = 1'b0;                                          // RULE4
    end
    if (asserted & CFG[FLD_EDGE]) begin
      edge_nxt = 1'b1;                                          // RULE4
    end
    if (!is_input) begin
      edge_nxt = 1'b0;                                          // RULE5
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || SUSPEND) begin
      edge_r <= 1'b0;
    end else begin
      edge_r <= edge_nxt;
    end
  end

  assign STATE = CFG[FLD_EDGE] ? (edge_r & is_input) : asserted; // RULE3 RULE4
  assign EVENT = asserted;

  property p_edge_hold;
    @(posedge CLK) disable iff (SYS_RST || SUSPEND)
      (is_input && CFG[FLD_EDGE] && asserted && !$past(SYS_RST)) |=> (edge_r || !is_input);
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge latch missed"); // RULE4

  property p_level;
    @(posedge CLK) disable iff (SYS_RST)
      (is_input && !CFG[FLD_EDGE]) |-> (STATE == (PIN_SYNC == CFG[FLD_POL]));
  endproperty
  a_level: assert property (p_level) else $error("level state wrong"); // RULE3

  property p_out_drive;
    @(posedge CLK) disable iff (SYS_RST)
      CFG[FLD_DIR] |-> (PIN_OE && PIN_O == CFG[FLD_OUT] && !STATE);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output drive wrong"); // RULE5 RULE6

  property p_in_float;
    @(posedge CLK) disable iff (SYS_RST)
      !CFG[FLD_DIR] |-> (!PIN_OE && !PIN_O);
  endproperty
  a_in_float: assert property (p_in_float) else $error("input pin driven"); // RULE1
endmodule // aux_pin_cell
`default_nettype wire

// ==== test/aux_pin_board.sv ====
// board model resolving the auxiliary pin levels
`default_nettype none
module aux_pin_board (
  // drive from the device
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  // level the board applies to a released pin
  input  wire logic [3:0] level,
  // resolved pin levels
  output logic      [3:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin follows the device, a released one follows the board
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pin_i[k] = pin_oe[k] ? pin_o[k] : level[k];
    end
  end
endmodule  // aux_pin_board
`default_nettype wire

// ==== test/aux_pin_config_port_tb.sv ====
// self-checking testbench for the auxiliary pin configuration port
`default_nettype none
module aux_pin_config_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aux_pin_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic       suspend;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] d;
  logic       wr;
  logic       rd;
  logic       irq;
  logic [3:0] pin_i;
  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  logic [3:0] level;
  int         miscompares;
  int         cmp_count;
  // ==========================================================
  // clock, design and board
  always #4 clk = ~clk;
  aux_pin_config_port i_aux_pin_config_port (
    .CLK(clk), .SYS_RST(sys_rst), .SUSPEND(suspend), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .IRQ(irq)
  );
  aux_pin_board i_aux_pin_board (.pin_o(pin_o), .pin_oe(pin_oe), .level(level), .pin_i(pin_i));
  // ==========================================================
  // bus tasks and compare
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
  // ==========================================================
  // tests
  initial begin
    clk = 1'b0; sys_rst = 1'b1; suspend = 1'b0; addr = 8'h00; wdata = 8'h00;
    wr = 1'b0; rd = 1'b0; level = 4'h0; miscompares = 0; cmp_count = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // defaults after reset
    rd_reg(OFF_CFG_34, d); chk8("cfg34", 8'h90, d);
    rd_reg(OFF_CFG_56, d); chk8("cfg56", 8'h39, d);
    chk8("drive", 8'hE6, {pin_oe, pin_o});
    rd_reg(8'h70, d); chk8("unmapped", 8'h00, d);
    // pins 5 and 6 as low-true, then high-true level inputs
    wr_reg(OFF_CFG_56, 8'h00); idle(1); chk8("oe", 8'h02, {4'h0, pin_oe});
    level <= 4'h8; idle(4);
    rd_reg(OFF_PIN_STATUS, d); chk8("lvl_low", 8'h04, d & 8'h0C);
    wr_reg(OFF_CFG_56, 8'h22); idle(4);
    rd_reg(OFF_PIN_STATUS, d); chk8("lvl_high", 8'h08, d & 8'h0C);
    // pin 6 high-true edge input: latch then clear on read
    wr_reg(OFF_CFG_56, 8'h60); level <= 4'h0; idle(4);
    rd_reg(OFF_PIN_STATUS, d);
    level <= 4'h8; idle(4); level <= 4'h0; idle(4);
    rd_reg(OFF_PIN_STATUS, d); chk8("edge_set", 8'h08, d & 8'h08);
    rd_reg(OFF_PIN_STATUS, d); chk8("edge_clr", 8'h00, d & 8'h08);
    // outputs ignore polarity and sensing, inputs ignore output state
    wr_reg(OFF_CFG_56, 8'h7F); idle(1); chk8("out", 8'h0D, {4'h0, pin_oe[3:2], pin_o[3:2]});
    wr_reg(OFF_CFG_56, 8'h88); idle(1); chk8("in", 8'h00, {4'h0, pin_oe[3:2], pin_o[3:2]});
    // interrupt raise, clear, mask
    wr_reg(OFF_CFG_56, 8'h02); idle(4);
    wr_reg(OFF_IRQ_CLEAR, 8'hFF); wr_reg(OFF_IRQ_ENABLE, 8'h04);
    level <= 4'h4; idle(4); chk8("irq_set", 8'h01, {7'h00, irq});
    rd_reg(OFF_IRQ_STATUS, d); chk8("irq_st", 8'h04, d & 8'h04);
    wr_reg(OFF_IRQ_CLEAR, 8'h04); idle(1); chk8("irq_clr", 8'h00, {7'h00, irq});
    wr_reg(OFF_IRQ_ENABLE, 8'h00); level <= 4'h0; idle(4);
    level <= 4'h4; idle(4); chk8("irq_mask", 8'h00, {7'h00, irq});
    wr_reg(OFF_IRQ_ENABLE, 8'h04); idle(1); chk8("irq_en", 8'h01, {7'h00, irq});
    wr_reg(OFF_IRQ_CLEAR, 8'h04); idle(1); chk8("irq_clr2", 8'h00, {7'h00, irq});
    // suspend returns defaults
    wr_reg(OFF_CFG_34, 8'h00);
    @(posedge clk); suspend <= 1'b1;
    idle(3); suspend <= 1'b0;
    rd_reg(OFF_CFG_34, d); chk8("susp34", 8'h90, d);
    rd_reg(OFF_CFG_56, d); chk8("susp56", 8'h39, d);
    chk8("susp_drive", 8'hE6, {pin_oe, pin_o});
    wrap_up;
  end
endmodule  // aux_pin_config_port_tb
`default_nettype wire
